// ===== rtl/iosc_pkg.sv
package iosc_pkg;

	// Port addresses of the I/O space.
	localparam logic [7:0] ADDR_GPIO_PORT0_DATA        = 8'h00;
	localparam logic [7:0] ADDR_GPIO_PORT1_DATA        = 8'h01;
	localparam logic [7:0] ADDR_AUX_INPUT_PORT         = 8'h02;
	localparam logic [7:0] ADDR_PORT0_IRQ_ENABLE       = 8'h04;
	localparam logic [7:0] ADDR_PORT1_IRQ_ENABLE       = 8'h05;
	localparam logic [7:0] ADDR_PORT0_IRQ_POLARITY     = 8'h06;
	localparam logic [7:0] ADDR_PORT1_IRQ_POLARITY     = 8'h07;
	localparam logic [7:0] ADDR_PORT0_DRIVE_MODE_A     = 8'h0a;
	localparam logic [7:0] ADDR_PORT0_DRIVE_MODE_B     = 8'h0b;
	localparam logic [7:0] ADDR_PORT1_DRIVE_MODE_A     = 8'h0c;
	localparam logic [7:0] ADDR_PORT1_DRIVE_MODE_B     = 8'h0d;
	localparam logic [7:0] ADDR_USB_FUNCTION_ADDRESS   = 8'h10;
	localparam logic [7:0] ADDR_ENDPOINT_ZERO_COUNT    = 8'h11;
	localparam logic [7:0] ADDR_ENDPOINT_ZERO_CONFIG   = 8'h12;
	localparam logic [7:0] ADDR_ENDPOINT_ONE_COUNT     = 8'h13;
	localparam logic [7:0] ADDR_ENDPOINT_ONE_CONFIG    = 8'h14;
	localparam logic [7:0] ADDR_ENDPOINT_TWO_COUNT     = 8'h15;
	localparam logic [7:0] ADDR_ENDPOINT_TWO_CONFIG    = 8'h16;
	localparam logic [7:0] ADDR_USB_STATUS_CONTROL     = 8'h1f;
	localparam logic [7:0] ADDR_GLOBAL_IRQ_ENABLE      = 8'h20;
	localparam logic [7:0] ADDR_ENDPOINT_IRQ_ENABLE    = 8'h21;
	localparam logic [7:0] ADDR_FREE_TIMER_LOW         = 8'h24;
	localparam logic [7:0] ADDR_FREE_TIMER_HIGH        = 8'h25;
	localparam logic [7:0] ADDR_WATCHDOG_KICK          = 8'h26;
	localparam logic [7:0] ADDR_CAPTURE_A_RISE         = 8'h40;
	localparam logic [7:0] ADDR_CAPTURE_A_FALL         = 8'h41;
	localparam logic [7:0] ADDR_CAPTURE_B_RISE         = 8'h42;
	localparam logic [7:0] ADDR_CAPTURE_B_FALL         = 8'h43;
	localparam logic [7:0] ADDR_CAPTURE_CONFIG         = 8'h44;
	localparam logic [7:0] ADDR_CAPTURE_STATUS         = 8'h45;
	localparam logic [7:0] ADDR_SERIAL_PORT_DATA       = 8'h60;
	localparam logic [7:0] ADDR_SERIAL_PORT_CONTROL    = 8'h61;
	localparam logic [7:0] ADDR_CLOCK_SOURCE_CONFIG    = 8'hf8;
	localparam logic [7:0] ADDR_PROCESSOR_STATUS_CTRL  = 8'hff;

	// Reset values.
	localparam logic [7:0] RESET_ZERO                  = 8'h00;
	localparam logic [7:0] RESET_CLOCK_SOURCE_CONFIG   = 8'h00;
	localparam logic [7:0] RESET_PROCESSOR_STATUS_CTRL = 8'h01;

	// Clock configuration field positions.
	localparam int CLK_RESUME_DELAY_BIT  = 7;
	localparam int CLK_WAKE_ADJ_MSB      = 6;
	localparam int CLK_WAKE_ADJ_LSB      = 4;
	localparam int CLK_LVR_DISABLE_BIT   = 3;
	localparam int CLK_PRECISION_BIT     = 2;
	localparam int CLK_OUT_DISABLE_BIT   = 1;
	localparam int CLK_EXT_OSC_BIT       = 0;

	// Auxiliary input bit positions.
	localparam int AUX_DPLUS_BIT         = 0;
	localparam int AUX_OSC_IN_BIT        = 1;
	localparam int AUX_REG_BIT           = 2;
	localparam int AUX_DMINUS_BIT        = 3;

	// Timer high register holds 4 bits.
	localparam int TIMER_WIDTH           = 12;
	localparam int TIMER_HIGH_WIDTH      = 4;

	// Data RAM size.
	localparam int RAM_DEPTH             = 256;

	// Timing figures.
	localparam int CLK_FREQ_HZ           = 100_000_000;
	localparam int TIMER_FREQ_HZ         = 1_000_000;
	localparam int TIMER_DIV             = CLK_FREQ_HZ / TIMER_FREQ_HZ;
	localparam int RESUME_LONG_US        = 4000;
	localparam int RESUME_SHORT_US       = 128;
	localparam int RESUME_INT_US         = 8;
	localparam int CYCLES_PER_US         = CLK_FREQ_HZ / 1_000_000;
	localparam int RESUME_LONG_CYC       = RESUME_LONG_US * CYCLES_PER_US;
	localparam int RESUME_SHORT_CYC      = RESUME_SHORT_US * CYCLES_PER_US;
	localparam int RESUME_INT_CYC        = RESUME_INT_US * CYCLES_PER_US;
	localparam int DELAY_WIDTH           = 20;

	typedef enum logic [1:0] {
		IOSC_RUN,
		IOSC_OSC_START,
		IOSC_RESUME_WAIT
	} iosc_state_t;

endpackage

// ===== rtl/iosc_io_space.sv
`timescale 1ns/100ps
`default_nettype none

module iosc_io_space
	import iosc_pkg::*;
(
	input  wire logic       core_clk,
	input  wire logic       srst,
	input  wire logic       portRead,
	input  wire logic       portWrite,
	input  wire logic       portWriteIndexed,
	input  wire logic [7:0] portAddr,
	input  wire logic [7:0] indexX,
	input  wire logic [7:0] accIn,
	output logic      [7:0] readData,
	input  wire logic       ramWrite,
	input  wire logic [7:0] ramAddr,
	input  wire logic [7:0] ramWriteData,
	output logic      [7:0] ramReadData,
	input  wire logic       usbDplus,
	input  wire logic       usbDminus,
	input  wire logic       regulatorPin,
	input  wire logic       oscillatorInputPin,
	input  wire logic [7:0] captureARise,
	input  wire logic [7:0] captureAFall,
	input  wire logic [7:0] captureBRise,
	input  wire logic [7:0] captureBFall,
	input  wire logic [7:0] captureStatus,
	input  wire logic       extClockStable,
	input  wire logic       suspendWake,
	output logic            coreHalt,
	output logic            externalClockActive,
	output logic            watchdogClear,
	output logic [7:0]      rwRegs [0:18],
	output logic [7:0]      woRegs [0:7],
	output logic [7:0]      clockSourceConfig,
	output logic [7:0]      processorStatusControl
);

	// Read/write register addresses, stored in rwRegs by index.
	localparam logic [7:0] RW_ADDRS [0:18] = '{
		ADDR_GPIO_PORT0_DATA, ADDR_GPIO_PORT1_DATA,
		ADDR_USB_FUNCTION_ADDRESS, ADDR_ENDPOINT_ZERO_COUNT,
		ADDR_ENDPOINT_ZERO_CONFIG, ADDR_ENDPOINT_ONE_COUNT,
		ADDR_ENDPOINT_ONE_CONFIG, ADDR_ENDPOINT_TWO_COUNT,
		ADDR_ENDPOINT_TWO_CONFIG, ADDR_USB_STATUS_CONTROL,
		ADDR_GLOBAL_IRQ_ENABLE, ADDR_ENDPOINT_IRQ_ENABLE,
		ADDR_CAPTURE_CONFIG, ADDR_SERIAL_PORT_DATA,
		ADDR_SERIAL_PORT_CONTROL, ADDR_CLOCK_SOURCE_CONFIG,
		ADDR_PROCESSOR_STATUS_CTRL, ADDR_GPIO_PORT0_DATA,
		ADDR_GPIO_PORT0_DATA
	};
	localparam int RW_COUNT = 15;

	// Write-only register addresses, stored in woRegs by index.
	localparam logic [7:0] WO_ADDRS [0:7] = '{
		ADDR_PORT0_IRQ_ENABLE, ADDR_PORT1_IRQ_ENABLE,
		ADDR_PORT0_IRQ_POLARITY, ADDR_PORT1_IRQ_POLARITY,
		ADDR_PORT0_DRIVE_MODE_A, ADDR_PORT0_DRIVE_MODE_B,
		ADDR_PORT1_DRIVE_MODE_A, ADDR_PORT1_DRIVE_MODE_B
	};

	logic [7:0]            writeAddr;
	logic                  writeStrobe;
	logic [7:0]            clockCfg_reg;
	logic [7:0]            procStatus_reg;
	logic [7:0]            ram_reg [0:RAM_DEPTH-1];
	logic [TIMER_WIDTH-1:0] timer_reg;
	logic [6:0]            timerDiv_reg;
	logic                  extActive_reg;
	iosc_state_t           state_reg;
	logic [DELAY_WIDTH-1:0] delay_reg;
	logic [DELAY_WIDTH-1:0] resumeCycles;
	logic [7:0]            rdMux;
	logic [3:0]            auxSync0_reg;
	logic [3:0]            auxSync1_reg;
	logic [3:0]            auxSync2_reg;
	logic [3:0]            aux_reg;
	logic [3:0]            auxRaw;

	// Target address: direct address, or X plus operand for indexed writes.
	always_comb begin
		writeStrobe = portWrite | portWriteIndexed;
		if (portWriteIndexed) begin
			writeAddr = 8'(indexX + portAddr);
		end else begin
			writeAddr = portAddr;
		end
	end

	// Read/write registers other than clock and processor status.
	genvar gi;
	generate
		for (gi = 0; gi < RW_COUNT; gi++) begin : gRw
			always_ff @(posedge core_clk) begin
				if (srst) begin
					rwRegs[gi] <= RESET_ZERO;
				end else if (writeStrobe && writeAddr == RW_ADDRS[gi]) begin
					rwRegs[gi] <= accIn;
				end
			end
		end
		for (gi = RW_COUNT; gi < 19; gi++) begin : gRwSpare
			assign rwRegs[gi] = RESET_ZERO;
		end
		for (gi = 0; gi < 8; gi++) begin : gWo
			always_ff @(posedge core_clk) begin
				if (srst) begin
					woRegs[gi] <= RESET_ZERO;
				end else if (writeStrobe && writeAddr == WO_ADDRS[gi]) begin
					woRegs[gi] <= accIn;
				end
			end
		end
	endgenerate

	// Clock configuration register, all eight bits read/write.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			clockCfg_reg <= RESET_CLOCK_SOURCE_CONFIG;
		end else if (writeStrobe && writeAddr == ADDR_CLOCK_SOURCE_CONFIG) begin
			clockCfg_reg <= accIn;
		end
	end

	// Processor status keeps its own reset value, not zero.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			procStatus_reg <= RESET_PROCESSOR_STATUS_CTRL;
		end else if (writeStrobe &&
		             writeAddr == ADDR_PROCESSOR_STATUS_CTRL) begin
			procStatus_reg <= accIn;
		end
	end

	// Watchdog clear pulses on any write to its address.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			watchdogClear <= 1'b0;
		end else begin
			watchdogClear <= writeStrobe &&
			                 writeAddr == ADDR_WATCHDOG_KICK;
		end
	end

	// Free-running 12-bit timer advanced by a 1 MHz enable.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			timerDiv_reg <= '0;
			timer_reg    <= '0;
		end else if (timerDiv_reg == 7'(TIMER_DIV - 1)) begin
			timerDiv_reg <= '0;
			timer_reg    <= timer_reg + 1'b1;
		end else begin
			timerDiv_reg <= timerDiv_reg + 1'b1;
		end
	end

	// Pin inputs pass three flops; a change counts when stages two and three agree.
	assign auxRaw = {usbDminus, regulatorPin, oscillatorInputPin, usbDplus};
	always_ff @(posedge core_clk) begin
		if (srst) begin
			auxSync0_reg <= '0;
			auxSync1_reg <= '0;
			auxSync2_reg <= '0;
			aux_reg      <= '0;
		end else begin
			auxSync0_reg <= auxRaw;
			auxSync1_reg <= auxSync0_reg;
			auxSync2_reg <= auxSync1_reg;
			aux_reg      <= (auxSync1_reg & auxSync2_reg) |
			                (aux_reg & (auxSync1_reg | auxSync2_reg));
		end
	end

	// Resume delay chosen by oscillator mode and bit 7.
	always_comb begin
		if (!clockCfg_reg[CLK_EXT_OSC_BIT]) begin
			resumeCycles = DELAY_WIDTH'(RESUME_INT_CYC);
		end else if (clockCfg_reg[CLK_RESUME_DELAY_BIT]) begin
			resumeCycles = DELAY_WIDTH'(RESUME_LONG_CYC);
		end else begin
			resumeCycles = DELAY_WIDTH'(RESUME_SHORT_CYC);
		end
	end

	// Clock switch sequencer: halt, wait for stable clock, then resume delay.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			state_reg     <= IOSC_RUN;
			delay_reg     <= '0;
			extActive_reg <= 1'b0;
		end else begin
			unique case (state_reg)
				IOSC_RUN: begin
					if (!extActive_reg && writeStrobe &&
					    writeAddr == ADDR_CLOCK_SOURCE_CONFIG &&
					    accIn[CLK_EXT_OSC_BIT]) begin
						state_reg <= IOSC_OSC_START;
					end else if (suspendWake) begin
						extActive_reg <= clockCfg_reg[CLK_EXT_OSC_BIT];
						state_reg     <= clockCfg_reg[CLK_EXT_OSC_BIT] ?
						                 IOSC_OSC_START : IOSC_RESUME_WAIT;
						delay_reg     <= resumeCycles;
					end
				end
				IOSC_OSC_START: begin
					if (extClockStable) begin
						extActive_reg <= 1'b1;
						delay_reg     <= resumeCycles;
						state_reg     <= IOSC_RESUME_WAIT;
					end
				end
				IOSC_RESUME_WAIT: begin
					if (delay_reg <= DELAY_WIDTH'(1)) begin
						state_reg <= IOSC_RUN;
					end else begin
						delay_reg <= delay_reg - 1'b1;
					end
				end
			endcase
		end
	end

	// Shared data RAM.
	always_ff @(posedge core_clk) begin
		if (ramWrite) begin
			ram_reg[ramAddr] <= ramWriteData;
		end
		ramReadData <= ram_reg[ramAddr];
	end

	// Read decode: write-only and unassigned addresses read zero.
	always_comb begin
		rdMux = RESET_ZERO;
		for (int i = 0; i < RW_COUNT; i++) begin
			if (portAddr == RW_ADDRS[i]) begin
				rdMux = rwRegs[i];
			end
		end
		unique case (portAddr)
			ADDR_AUX_INPUT_PORT: rdMux = {4'h0, aux_reg};
			ADDR_FREE_TIMER_LOW: rdMux = timer_reg[7:0];
			ADDR_FREE_TIMER_HIGH: begin
				rdMux = {4'h0, timer_reg[TIMER_WIDTH-1:8]};
			end
			ADDR_CAPTURE_A_RISE: rdMux = captureARise;
			ADDR_CAPTURE_A_FALL: rdMux = captureAFall;
			ADDR_CAPTURE_B_RISE: rdMux = captureBRise;
			ADDR_CAPTURE_B_FALL: rdMux = captureBFall;
			ADDR_CAPTURE_STATUS: rdMux = captureStatus;
			ADDR_CLOCK_SOURCE_CONFIG: rdMux = clockCfg_reg;
			ADDR_PROCESSOR_STATUS_CTRL: rdMux = procStatus_reg;
			default: begin
			end
		endcase
	end

	// Read data registered on the read strobe.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			readData <= RESET_ZERO;
		end else if (portRead) begin
			readData <= rdMux;
		end
	end

	assign coreHalt               = (state_reg != IOSC_RUN);
	assign externalClockActive    = extActive_reg;
	assign clockSourceConfig      = clockCfg_reg;
	assign processorStatusControl = procStatus_reg;

endmodule

`default_nettype wire

// ===== test/iosc_io_checker.sv
`timescale 1ns/100ps
`default_nettype none

module iosc_io_checker
	import iosc_pkg::*;
(
	input wire logic       core_clk,
	input wire logic       srst,
	input wire logic       portRead,
	input wire logic       portWrite,
	input wire logic       portWriteIndexed,
	input wire logic [7:0] portAddr,
	input wire logic [7:0] indexX,
	input wire logic [7:0] accIn,
	input wire logic [7:0] readData,
	input wire logic       suspendWake,
	input wire logic       coreHalt,
	input wire logic       externalClockActive,
	input wire logic       watchdogClear,
	input wire logic [7:0] rwRegs [0:18],
	input wire logic [7:0] clockSourceConfig,
	input wire logic [7:0] processorStatusControl
);
	localparam int HALT_MIN = 790;
	logic [7:0]  idxAddr;
	logic        clkWr;
	logic        kick;
	logic [19:0] haltCnt;

	// Target of an indexed write, and writes that reach the clock register.
	assign idxAddr = indexX + portAddr;
	assign clkWr = (portWrite && portAddr == ADDR_CLOCK_SOURCE_CONFIG)
		|| (portWriteIndexed && idxAddr == ADDR_CLOCK_SOURCE_CONFIG);
	assign kick = (portWrite && portAddr == ADDR_WATCHDOG_KICK)
		|| (portWriteIndexed && idxAddr == ADDR_WATCHDOG_KICK);

	// Length of the current halt, so its end can be judged.
	always_ff @(posedge core_clk) begin
		if (srst || !coreHalt) begin
			haltCnt <= '0;
		end else begin
			haltCnt <= haltCnt + 20'h1;
		end
	end

	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);

	a_reset_values: assert property ($fell(srst) |-> clockSourceConfig == 8'h00
		&& processorStatusControl == RESET_PROCESSOR_STATUS_CTRL && !coreHalt)
		else $error("register not at reset value");
	a_clock_write: assert property (clkWr |=> clockSourceConfig == $past(accIn))
		else $error("clock register write lost");
	a_clock_hold: assert property (!clkWr |=> $stable(clockSourceConfig))
		else $error("clock register changed unwritten");
	a_kick_pulse: assert property (kick |=> watchdogClear ##1 !watchdogClear)
		else $error("watchdog clear not one pulse");
	a_kick_cause: assert property (watchdogClear |-> $past(kick))
		else $error("watchdog clear without write");
	a_unused_read: assert property (portRead && (portAddr == 8'h03
		|| portAddr == ADDR_WATCHDOG_KICK) |-> ##2 readData == 8'h00)
		else $error("unreadable address gave data");
	a_serial_read: assert property (portRead && portAddr == ADDR_SERIAL_PORT_DATA
		|-> ##2 readData == rwRegs[13]) else $error("read data wrong");
	a_ext_halt: assert property (clkWr && accIn[CLK_EXT_OSC_BIT]
		&& !externalClockActive |=> coreHalt) else $error("no halt on switch");
	a_ext_sticky: assert property (externalClockActive && !suspendWake
		|=> externalClockActive) else $error("external clock dropped");
	a_halt_min: assert property ($fell(coreHalt) |-> $past(haltCnt) >= HALT_MIN)
		else $error("halt too short");

	c_switch: cover property (clkWr && accIn[CLK_EXT_OSC_BIT]);
	c_release: cover property ($fell(coreHalt));
	c_kick: cover property (watchdogClear);
	c_indexed: cover property (portWriteIndexed);
endmodule

bind iosc_io_space iosc_io_checker iosc_io_checker_i (.core_clk(core_clk),
	.srst(srst), .portRead(portRead), .portWrite(portWrite),
	.portWriteIndexed(portWriteIndexed), .portAddr(portAddr), .indexX(indexX),
	.accIn(accIn), .readData(readData), .suspendWake(suspendWake),
	.coreHalt(coreHalt), .externalClockActive(externalClockActive),
	.watchdogClear(watchdogClear), .rwRegs(rwRegs),
	.clockSourceConfig(clockSourceConfig),
	.processorStatusControl(processorStatusControl));
`default_nettype wire

// ===== test/iosc_cpu_model.sv
`timescale 1ns/100ps
`default_nettype none

module iosc_cpu_model
(
	input  wire logic       core_clk,
	output logic            portRead,
	output logic            portWrite,
	output logic            portWriteIndexed,
	output logic      [7:0] portAddr,
	output logic      [7:0] indexX,
	output logic      [7:0] accIn,
	input  wire logic [7:0] readData
);
	// The core starts idle with no strobe raised.
	initial begin
		{portRead, portWrite, portWriteIndexed} = 3'b000;
		{portAddr, indexX, accIn} = 24'h0;
	end

	// One port write; operands are inverted once taken so stale values never pass.
	task automatic ioPut(input logic idx, input logic [7:0] x, a, d);
		@(posedge core_clk);
		portWrite <= !idx;
		portWriteIndexed <= idx;
		{indexX, portAddr, accIn} <= {x, a, d};
		@(posedge core_clk);
		{portWrite, portWriteIndexed} <= 2'b00;
		{indexX, portAddr, accIn} <= ~{x, a, d};
		#1;
	endtask

	// One port read; the answer is taken a cycle after the read edge.
	task automatic ioGet(input logic [7:0] a, output logic [7:0] d);
		@(posedge core_clk);
		portRead <= 1'b1;
		portAddr <= a;
		@(posedge core_clk);
		portRead <= 1'b0;
		portAddr <= ~a;
		@(posedge core_clk);
		#1;
		d = readData;
	endtask
endmodule
`default_nettype wire

// ===== test/testbench.sv
`timescale 1ns/100ps
`default_nettype none

module testbench
	import iosc_pkg::*;
;
	localparam logic [7:0] RW_A [0:14] = '{8'h00, 8'h01, 8'h10, 8'h11, 8'h12,
		8'h13, 8'h14, 8'h15, 8'h16, 8'h1f, 8'h20, 8'h21, 8'h44, 8'h60, 8'h61};
	localparam logic [7:0] WO_A [0:7] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h0a,
		8'h0b, 8'h0c, 8'h0d};
	localparam logic [7:0] RO_A [0:4] = '{8'h40, 8'h41, 8'h42, 8'h43, 8'h45};
	logic       core_clk, srst, ramWrite, extClockStable, suspendWake;
	logic       usbDplus, usbDminus, regulatorPin, oscillatorInputPin;
	logic       portRead, portWrite, portWriteIndexed;
	logic       coreHalt, externalClockActive, watchdogClear;
	logic [7:0] portAddr, indexX, accIn, readData, rd, t0;
	logic [7:0] ramAddr, ramWriteData, ramReadData;
	logic [7:0] clockSourceConfig, processorStatusControl;
	logic [7:0] cap [0:4];
	logic [7:0] rwRegs [0:18];
	logic [7:0] woRegs [0:7];
	int         numErrors, totalChecks, n;

	iosc_io_space iosc_io_space_i (.core_clk(core_clk), .srst(srst),
		.portRead(portRead), .portWrite(portWrite),
		.portWriteIndexed(portWriteIndexed), .portAddr(portAddr),
		.indexX(indexX), .accIn(accIn), .readData(readData),
		.ramWrite(ramWrite), .ramAddr(ramAddr), .ramWriteData(ramWriteData),
		.ramReadData(ramReadData), .usbDplus(usbDplus), .usbDminus(usbDminus),
		.regulatorPin(regulatorPin), .oscillatorInputPin(oscillatorInputPin),
		.captureARise(cap[0]), .captureAFall(cap[1]), .captureBRise(cap[2]),
		.captureBFall(cap[3]), .captureStatus(cap[4]),
		.extClockStable(extClockStable), .suspendWake(suspendWake),
		.coreHalt(coreHalt), .externalClockActive(externalClockActive),
		.watchdogClear(watchdogClear), .rwRegs(rwRegs), .woRegs(woRegs),
		.clockSourceConfig(clockSourceConfig),
		.processorStatusControl(processorStatusControl));

	iosc_cpu_model iosc_cpu_model_i (.core_clk(core_clk), .portRead(portRead),
		.portWrite(portWrite), .portWriteIndexed(portWriteIndexed),
		.portAddr(portAddr), .indexX(indexX), .accIn(accIn),
		.readData(readData));

	// Free-running 100 MHz clock.
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	// Compares one value and reports a difference.
	task automatic check(input string nm, input logic [7:0] e, g);
		totalChecks++;
		if (g !== e) begin
			numErrors++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wr(input logic [7:0] a, d);
		iosc_cpu_model_i.ioPut(1'b0, 8'h00, a, d);
	endtask

	task automatic rdc(input logic [7:0] a, e);
		iosc_cpu_model_i.ioGet(a, rd);
		check($sformatf("port%h", a), e, rd);
	endtask

	// Measures how long the core stays halted from now.
	task automatic waitHalt(input int e);
		n = 0;
		#1;
		while (coreHalt !== 1'b0 && n < 20000) begin
			@(posedge core_clk);
			#1;
			n++;
		end
		check("haltLen", 8'h01, {7'h0, n >= e - 3 && n <= e + 3});
	endtask

	// The rwRegs, woRegs, clock and processor status outputs must show their reset values.
	task automatic resetCheck();
		for (int i = 0; i < 15; i++) check("rwReg", 8'h00, rwRegs[i]);
		for (int i = 0; i < 8; i++) check("woReg", 8'h00, woRegs[i]);
		check("clkCfg", 8'h00, clockSourceConfig);
		check("psc", RESET_PROCESSOR_STATUS_CTRL, processorStatusControl);
		$display("test reset done");
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", totalChecks, numErrors);
		if (numErrors == 0 && totalChecks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// Cuts a hang short well past the expected run length.
	initial begin
		repeat (80000) @(posedge core_clk);
		numErrors++;
		complete_run();
	end

	// Main sequence of tests.
	initial begin
		srst = 1'b1;
		{ramWrite, extClockStable, suspendWake} = 3'b000;
		{usbDminus, regulatorPin, oscillatorInputPin, usbDplus} = 4'b0000;
		{ramAddr, ramWriteData} = 16'h0;
		cap = '{8'h5a, 8'ha5, 8'h3c, 8'hc3, 8'h81};
		repeat (12) @(posedge core_clk);
		srst <= 1'b0;
		@(posedge core_clk);
		#1;
		resetCheck();
		for (int i = 0; i < 15; i++) begin
			wr(RW_A[i], RW_A[i] ^ 8'h5a);
			check("rwReg", RW_A[i] ^ 8'h5a, rwRegs[i]);
			rdc(RW_A[i], RW_A[i] ^ 8'h5a);
		end
		for (int i = 0; i < 8; i++) begin
			wr(WO_A[i], 8'h81 + i[7:0]);
			check("woReg", 8'h81 + i[7:0], woRegs[i]);
			rdc(WO_A[i], 8'h00);
		end
		for (int i = 0; i < 5; i++) begin
			wr(RO_A[i], 8'hff);
			rdc(RO_A[i], cap[i]);
		end
		rdc(8'h03, 8'h00);
		rdc(ADDR_WATCHDOG_KICK, 8'h00);
		@(posedge core_clk);
		{usbDminus, regulatorPin, oscillatorInputPin, usbDplus} <= 4'b1101;
		repeat (4) @(posedge core_clk);
		iosc_cpu_model_i.ioGet(ADDR_AUX_INPUT_PORT, rd);
		check("aux", 8'h0d, {4'h0, rd[3:0]});
		$display("test access done");
		iosc_cpu_model_i.ioPut(1'b1, 8'h10, 8'h03, 8'h77);
		check("idx", 8'h77, rwRegs[5]);
		iosc_cpu_model_i.ioPut(1'b1, 8'h60, 8'h00, 8'h66);
		check("idxZero", 8'h66, rwRegs[13]);
		iosc_cpu_model_i.ioPut(1'b1, 8'hf0, 8'h11, 8'h55);
		check("idxWrap", 8'h55, rwRegs[1]);
		wr(ADDR_WATCHDOG_KICK, 8'h00);
		check("kick", 8'h01, {7'h0, watchdogClear});
		@(posedge core_clk);
		#1;
		check("kickEnd", 8'h00, {7'h0, watchdogClear});
		iosc_cpu_model_i.ioGet(ADDR_FREE_TIMER_LOW, t0);
		repeat (997) @(posedge core_clk);
		iosc_cpu_model_i.ioGet(ADDR_FREE_TIMER_LOW, rd);
		check("timer", t0 + 8'd10, rd);
		rdc(ADDR_FREE_TIMER_HIGH, 8'h00);
		$display("test index timer done");
		for (int i = 0; i < 2; i++) begin
			@(posedge core_clk);
			ramWrite <= 1'b1;
			ramAddr <= {8{i[0]}};
			ramWriteData <= 8'h3c + i[7:0];
		end
		@(posedge core_clk);
		ramWrite <= 1'b0;
		for (int i = 0; i < 2; i++) begin
			@(posedge core_clk);
			ramAddr <= {8{i[0]}};
			repeat (2) @(posedge core_clk);
			#1;
			check("ram", 8'h3c + i[7:0], ramReadData);
		end
		wr(ADDR_CLOCK_SOURCE_CONFIG, 8'h01);
		check("halt", 8'h01, {7'h0, coreHalt});
		repeat (20) @(posedge core_clk);
		extClockStable <= 1'b1;
		waitHalt(12800);
		check("extOn", 8'h01, {7'h0, externalClockActive});
		wr(ADDR_CLOCK_SOURCE_CONFIG, 8'h80);
		check("extKept", 8'h01, {7'h0, externalClockActive});
		@(posedge core_clk);
		suspendWake <= 1'b1;
		@(posedge core_clk);
		suspendWake <= 1'b0;
		extClockStable <= 1'b0;
		waitHalt(800);
		check("extOff", 8'h00, {7'h0, externalClockActive});
		wr(ADDR_CLOCK_SOURCE_CONFIG, 8'h01);
		@(posedge core_clk);
		extClockStable <= 1'b1;
		waitHalt(12800);
		@(posedge core_clk);
		suspendWake <= 1'b1;
		@(posedge core_clk);
		suspendWake <= 1'b0;
		waitHalt(12800);
		check("extWake", 8'h01, {7'h0, externalClockActive});
		rdc(ADDR_CLOCK_SOURCE_CONFIG, 8'h01);
		wr(ADDR_PROCESSOR_STATUS_CTRL, 8'h42);
		rdc(ADDR_PROCESSOR_STATUS_CTRL, 8'h42);
		$display("test clock done");
		@(posedge core_clk);
		srst <= 1'b1;
		repeat (2) @(posedge core_clk);
		srst <= 1'b0;
		@(posedge core_clk);
		#1;
		resetCheck();
		complete_run();
	end
endmodule
`default_nettype wire
